// ==== stfh_regs.vh ====
// Constants for the serial transmit flow hold block
`ifndef STFH_REGS_VH
`define STFH_REGS_VH
`define STFH_XOFF 8'h13
`define STFH_XON 8'h11
`define STFH_DW 8
`define STFH_AW 1
`define STFH_DEPTH 2
`define STFH_CNT_FULL 2'h2
`define STFH_CNT_EMPTY 2'h0
`define STFH_CNT_STEP 2'h1
`endif

// ==== stfh_mem.v ====
// Two-entry word store with registered read data
`timescale 1ns/10ps
`include "stfh_regs.vh"
module stfh_mem #(
    parameter DW = `STFH_DW,
    parameter AW = `STFH_AW
) (
    input wire clk,
    input wire nrst,
    input wire ce,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    always @(posedge clk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= {DW{1'b0}};
        end else if (ce) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// ==== stfh_gate.v ====
// Transmit flow hold: XOFF/XON and hold line gating of outgoing characters
`timescale 1ns/10ps
`include "stfh_regs.vh"
module stfh_gate #(
    parameter DW = `STFH_DW
) (
    input wire CLK,
    input wire NRST,
    input wire CE,
    input wire [DW-1:0] SRC_DATA,
    input wire SRC_VALID,
    output reg SRC_READY,
    output reg [DW-1:0] TX_DATA,
    output reg TX_VALID,
    input wire TX_READY,
    input wire [DW-1:0] RX_DATA,
    input wire RX_VALID,
    input wire HOLD_LINE_N_PRESENT,
    input wire HOLD_LINE,
    input wire PRINT_ACTIVE,
    input wire REMOTE_LOCKOUT_SET,
    input wire REMOTE_LOCKOUT_CLR,
    output reg XOFF_HELD,
    output reg PANEL_BUSY,
    output reg PANEL_LOCKED
);
    localparam [2:0] S_IDLE = 3'h1;
    localparam [2:0] S_LOAD = 3'h2;
    localparam [2:0] S_SHOW = 3'h4;

    reg xoff_r;
    reg xoff_nxt;
    reg lock_r;
    reg [1:0] cnt_r;
    reg [1:0] cnt_nxt;
    reg wp_r;
    reg rp_r;
    reg ra_r;
    reg staged_r;
    reg [2:0] st_r;
    reg [2:0] st_nxt;
    wire [DW-1:0] mem_q;
    wire line_ok;
    wire hold;
    wire push;
    wire pop;
    wire out_free;
    wire raise;
    wire pending;

    // Missing line reads as asserted
    assign line_ok = HOLD_LINE | ~HOLD_LINE_N_PRESENT;
    assign hold = xoff_r | ~line_ok;
    assign push = SRC_VALID && (cnt_r != `STFH_CNT_FULL);
    assign out_free = ~TX_VALID | TX_READY;
    assign pop = (st_r == S_IDLE) && !staged_r && (cnt_r != `STFH_CNT_EMPTY)
        && out_free && ~hold;
    // A word offered is never withdrawn; holds stop the next offer
    assign raise = staged_r && ~hold;
    assign pending = (st_r != S_IDLE) || staged_r || TX_VALID
        || (cnt_r != `STFH_CNT_EMPTY);

    always @* begin
        xoff_nxt = xoff_r;
        if (RX_VALID && RX_DATA == `STFH_XOFF) begin
            xoff_nxt = 1'b1;
        end else if (RX_VALID && RX_DATA == `STFH_XON) begin
            xoff_nxt = 1'b0;
        end
    end

    always @* begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + `STFH_CNT_STEP;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - `STFH_CNT_STEP;
        end
    end

    always @* begin
        st_nxt = st_r;
        case (st_r)
            S_IDLE: begin
                if (pop) begin
                    st_nxt = S_LOAD;
                end
            end
            S_LOAD: begin
                st_nxt = S_SHOW;
            end
            S_SHOW: begin
                st_nxt = S_IDLE;
            end
            default: begin
                st_nxt = S_IDLE;
            end
        endcase
    end

    stfh_mem #(
        .DW(DW),
        .AW(`STFH_AW)
    ) u_mem (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .wr_en(push),
        .wr_addr(wp_r),
        .wr_data(SRC_DATA),
        .rd_addr(ra_r),
        .rd_data(mem_q)
    );

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            xoff_r <= 1'b0;
        end else if (CE) begin
            xoff_r <= xoff_nxt;
        end
    end

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            lock_r <= 1'b0;
        end else if (CE) begin
            if (REMOTE_LOCKOUT_SET) begin
                lock_r <= 1'b1;
            end else if (REMOTE_LOCKOUT_CLR) begin
                lock_r <= 1'b0;
            end
        end
    end

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cnt_r <= `STFH_CNT_EMPTY;
        end else if (CE) begin
            cnt_r <= cnt_nxt;
        end
    end

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            wp_r <= 1'b0;
        end else if (CE && push) begin
            wp_r <= ~wp_r;
        end
    end

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rp_r <= 1'b0;
        end else if (CE && pop) begin
            rp_r <= ~rp_r;
        end
    end

    // Read slot frozen at pop so the registered read sees the popped word
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ra_r <= 1'b0;
        end else if (CE && pop) begin
            ra_r <= rp_r;
        end
    end

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            st_r <= S_IDLE;
        end else if (CE) begin
            st_r <= st_nxt;
        end
    end

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            staged_r <= 1'b0;
        end else if (CE) begin
            if (st_r == S_SHOW) begin
                staged_r <= 1'b1;
            end else if (raise) begin
                staged_r <= 1'b0;
            end
        end
    end

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            SRC_READY <= 1'b0;
        end else if (CE) begin
            SRC_READY <= (cnt_nxt != `STFH_CNT_FULL);
        end
    end

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            TX_DATA <= {DW{1'b0}};
        end else if (CE && st_r == S_SHOW) begin
            TX_DATA <= mem_q;
        end
    end

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            TX_VALID <= 1'b0;
        end else if (CE) begin
            if (TX_VALID && TX_READY) begin
                TX_VALID <= 1'b0;
            end else if (raise) begin
                TX_VALID <= 1'b1;
            end
        end
    end

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            XOFF_HELD <= 1'b0;
        end else if (CE) begin
            XOFF_HELD <= xoff_nxt;
        end
    end

    // Print stalls the panel while held and while any character is still pending
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            PANEL_BUSY <= 1'b0;
        end else if (CE) begin
            PANEL_BUSY <= PRINT_ACTIVE && (xoff_nxt || !line_ok || pending);
        end
    end

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            PANEL_LOCKED <= 1'b0;
        end else if (CE) begin
            PANEL_LOCKED <= REMOTE_LOCKOUT_SET
                || (lock_r && !REMOTE_LOCKOUT_CLR);
        end
    end
endmodule

// ==== stfh_gate_assertions.sv ====
// Checker for the transmit flow hold gate
`timescale 1ns/10ps
module stfh_chk (
    input wire CLK,
    input wire NRST,
    input wire [7:0] RX_DATA,
    input wire RX_VALID,
    input wire [7:0] TX_DATA,
    input wire TX_VALID,
    input wire TX_READY,
    input wire HOLD_LINE_N_PRESENT,
    input wire HOLD_LINE,
    input wire XOFF_HELD,
    input wire PRINT_ACTIVE,
    input wire PANEL_BUSY,
    input wire REMOTE_LOCKOUT_SET,
    input wire PANEL_LOCKED
);
default clocking @(posedge CLK); endclocking
default disable iff (!NRST);
a_xoff_sets: assert property (RX_VALID && RX_DATA == 8'h13 |=> XOFF_HELD)
    else $error("xoff ignored");
a_xon_clears: assert property (RX_VALID && RX_DATA == 8'h11 |=> !XOFF_HELD)
    else $error("xon ignored");
a_held_stalls: assert property (XOFF_HELD && !TX_VALID |=> !TX_VALID)
    else $error("char offered under xoff");
a_line_stalls: assert property (HOLD_LINE_N_PRESENT && !HOLD_LINE && !TX_VALID |=> !TX_VALID)
    else $error("char offered under line hold");
a_absent_sends: assert property (!HOLD_LINE_N_PRESENT && !XOFF_HELD && !RX_VALID
    && TX_VALID && TX_READY |=> !TX_VALID) else $error("char not sent");
a_busy_held: assert property (PRINT_ACTIVE && XOFF_HELD && !RX_VALID |=> PANEL_BUSY)
    else $error("panel not busy");
a_idle_free: assert property (!PRINT_ACTIVE ##1 !PRINT_ACTIVE |-> !PANEL_BUSY)
    else $error("panel busy without print");
a_lock_sets: assert property (REMOTE_LOCKOUT_SET |=> PANEL_LOCKED)
    else $error("lockout not set");
c_held: cover property (XOFF_HELD && TX_VALID);
c_sent: cover property (TX_VALID && TX_READY);
c_locked: cover property (PANEL_LOCKED);
endmodule
bind stfh_gate stfh_chk stfh_chk_i (.*);

// ==== stfh_sink.sv ====
// Serializer model that stalls every other cycle
`timescale 1ns/10ps
module stfh_sink (
    input wire clk,
    input wire valid,
    input wire [7:0] data,
    output reg ready
);
reg [7:0] got [0:15];
integer n = 0;
initial ready = 0;
always @(posedge clk) begin
    if (valid && ready) begin
        got[n] <= data;
        n <= n + 1;
    end
    ready <= #1 ~ready;
end
endmodule

// ==== stfh_gate_tb_top.sv ====
// Testbench top for the transmit flow hold gate
`timescale 1ns/10ps
module stfh_gate_tb_top;
reg clk = 0, nrst = 0, sv = 0, rv = 0, np = 1, hl = 1, pa = 0, ls = 0, lc = 0;
reg [7:0] sd = 0, rd = 0;
wire sr, tv, tr, xh, pb, pl;
wire [7:0] td;
integer miscompares = 0, checks = 0, k, i, b;
stfh_gate stfh_gate_i (.CLK(clk), .NRST(nrst), .CE(1'b1), .SRC_DATA(sd), .SRC_VALID(sv),
    .SRC_READY(sr), .TX_DATA(td), .TX_VALID(tv), .TX_READY(tr), .RX_DATA(rd), .RX_VALID(rv),
    .HOLD_LINE_N_PRESENT(np), .HOLD_LINE(hl), .PRINT_ACTIVE(pa), .REMOTE_LOCKOUT_SET(ls),
    .REMOTE_LOCKOUT_CLR(lc), .XOFF_HELD(xh), .PANEL_BUSY(pb), .PANEL_LOCKED(pl));
stfh_sink stfh_sink_i (.clk(clk), .valid(tv), .data(td), .ready(tr));
initial forever #50 clk = ~clk;
task chk(input [7:0] s, input [7:0] e); begin
    checks = checks + 1;
    if (s !== e) begin
        miscompares = miscompares + 1;
        $display("BAD %0t saw %h want %h", $time, s, e);
    end
end endtask
task rx(input [7:0] c); begin
    rd = c; rv = 1; @(posedge clk); #1 rv = 0;
end endtask
task w(input integer c); begin
    repeat (c) @(posedge clk); #1;
end endtask
task t_fill; begin
    b = stfh_sink_i.n; rx(8'h13); k = 0; sd = 8'h40; sv = 1;
    repeat (8) begin @(posedge clk); if (sr) k = k + 1; #1 sd = 8'h40 + k; end
    sv = 0; chk(sr, 0); chk(k > 1, 1); w(40); chk(stfh_sink_i.n, b);
    chk(xh, 1);
    rx(8'h11); w(40); chk(stfh_sink_i.n, b + k);
    chk(xh, 0);
    for (i = 0; i < k; i = i + 1) chk(stfh_sink_i.got[b + i], 8'h40 + i);
    $display("fill test done");
end endtask
task t_line; begin
    b = stfh_sink_i.n; hl = 0; sd = 8'h5a; sv = 1; w(1); sv = 0;
    w(20); chk(stfh_sink_i.n, b); np = 0; w(20); chk(stfh_sink_i.n, b + 1);
    chk(stfh_sink_i.got[b], 8'h5a); np = 1; hl = 1;
    $display("line test done");
end endtask
task t_panel; begin
    pa = 1; rx(8'h13); sv = 1; w(1); sv = 0; w(8); chk(pb, 1);
    rx(8'h11); w(30); chk(pb, 0); pa = 0;
    ls = 1; lc = 1; w(1); ls = 0; lc = 0; w(2); chk(pl, 1);
    lc = 1; w(1); lc = 0; w(2); chk(pl, 0);
    $display("panel test done");
end endtask
task end_of_test; begin
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
end endtask
initial begin #200000 miscompares = miscompares + 1; end_of_test; end
initial begin
    w(4); nrst = 1; w(2);
    t_fill; t_line; t_panel; end_of_test;
end
endmodule
